// [hw/wm_pkg.sv]
package wm_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int OP_W     = 35;
   localparam int SLICE_W  = 18;
   localparam int PROD_W   = 36;
   localparam int ACC_W    = 48;
   localparam int LOW_W    = 17;
   localparam int SEL_W    = 7;
   localparam int SEG_W    = 36;
   localparam int SHIFT    = 17;

   // ==========================================================
   // Datapath select codes and field positions
   // ==========================================================
   localparam logic [SEL_W-1:0] SEL_LOAD      = 7'h05;
   localparam logic [SEL_W-1:0] SEL_ACC       = 7'h25;
   localparam logic [SEL_W-1:0] SEL_SHIFT_ACC = 7'h65;
   localparam int               ZSEL_LSB      = 4;
   localparam logic [2:0]       Z_ZERO        = 3'h0;
   localparam logic [2:0]       Z_FEEDBACK    = 3'h2;
   localparam logic [2:0]       Z_SHIFTED     = 3'h6;

   // ==========================================================
   // Step indices, segment indices and reset values
   // ==========================================================
   localparam logic [1:0] STEP_0     = 2'h0;
   localparam logic [1:0] STEP_1     = 2'h1;
   localparam logic [1:0] STEP_2     = 2'h2;
   localparam logic [1:0] STEP_3     = 2'h3;
   localparam logic [1:0] SEG_0      = 2'h0;
   localparam logic [1:0] SEG_1      = 2'h1;
   localparam logic [1:0] SEG_2      = 2'h2;
   localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;

   typedef enum logic
   {
      WM_MODE_35X18 = 1'b0,
      WM_MODE_35X35 = 1'b1
   } wm_mode_e;

   typedef enum logic [1:0]
   {
      WM_ST_IDLE  = 2'b00,
      WM_ST_RUN   = 2'b01,
      WM_ST_DRAIN = 2'b10
   } wm_state_e;

endpackage

// [hw/wm_slice_if.sv]
`timescale 1ns/10ps

interface wm_slice_if;
   logic signed [wm_pkg::SLICE_W-1:0] a;
   logic signed [wm_pkg::SLICE_W-1:0] b;
   logic        [wm_pkg::SEL_W-1:0]   datapath_select_code;
   logic                              en;
   logic        [1:0]                 tag;
   logic signed [wm_pkg::ACC_W-1:0]   p;
   logic                              p_valid;
   logic        [1:0]                 p_tag;

   modport ctrl
   (
      output a,
      output b,
      output datapath_select_code,
      output en,
      output tag,
      input  p,
      input  p_valid,
      input  p_tag
   );

   modport slice
   (
      input  a,
      input  b,
      input  datapath_select_code,
      input  en,
      input  tag,
      output p,
      output p_valid,
      output p_tag
   );
endinterface

// [hw/wm_slice.sv]
`timescale 1ns/10ps

module wm_slice #(
   parameter int USE_MREG = 0
)(
   input wire logic  i_clk_sys,
   input wire logic  i_reset_n,
   wm_slice_if.slice bus
);

   logic signed [wm_pkg::PROD_W-1:0] prod;
   logic signed [wm_pkg::PROD_W-1:0] m_prod;
   logic        [wm_pkg::SEL_W-1:0]  m_sel;
   logic                             m_en;
   logic        [1:0]                m_tag;
   logic signed [wm_pkg::ACC_W-1:0]  ext;
   logic signed [wm_pkg::ACC_W-1:0]  zin;
   logic signed [wm_pkg::ACC_W-1:0]  next_p;
   logic                             next_p_valid;
   logic        [1:0]                next_p_tag;

   assign prod = bus.a * bus.b;

   // ==========================================================
   // Optional register after the multiplier
   // ==========================================================
   // It shortens the multiply-to-adder path at the cost of one
   // cycle per step; the sequencer spaces its steps to match.
   generate
      if (USE_MREG != 0)
      begin : g_mreg
         always_ff @(posedge i_clk_sys or negedge i_reset_n)
         begin
            if (!i_reset_n)
            begin
               m_prod <= '0;
               m_sel  <= wm_pkg::SEL_RESET;
               m_en   <= 1'b0;
               m_tag  <= 2'h0;
            end
            else
            begin
               m_prod <= prod; // [RQ15]
               m_sel  <= bus.datapath_select_code;
               m_en   <= bus.en;
               m_tag  <= bus.tag;
            end
         end
      end
      else
      begin : g_nomreg
         assign m_prod = prod;
         assign m_sel  = bus.datapath_select_code;
         assign m_en   = bus.en;
         assign m_tag  = bus.tag;
      end
   endgenerate

   // ==========================================================
   // Adder input select and result register
   // ==========================================================
   always_comb
   begin
      ext = {{(wm_pkg::ACC_W-wm_pkg::PROD_W){m_prod[wm_pkg::PROD_W-1]}},
             m_prod}; // [RQ10]
      unique case (m_sel[wm_pkg::ZSEL_LSB +: 3])
         wm_pkg::Z_FEEDBACK : zin = bus.p; // [RQ17]
         wm_pkg::Z_SHIFTED  : zin = bus.p >>> wm_pkg::SHIFT;
         default            : zin = '0; // [RQ16]
      endcase
      next_p       = m_en ? ext + zin : bus.p;
      next_p_valid = m_en;
      next_p_tag   = m_en ? m_tag : bus.p_tag;
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         bus.p       <= '0;
         bus.p_valid <= 1'b0;
         bus.p_tag   <= 2'h0;
      end
      else
      begin
         bus.p       <= next_p;
         bus.p_valid <= next_p_valid;
         bus.p_tag   <= next_p_tag;
      end
   end

endmodule

// [hw/wm_mult.sv]
// Operation
// RQ1 - 35x18 mode: signed operands, signed 53-bit product.
// RQ2 - Split operand lower part has top bit zero.
// RQ3 - 35x18 uses one slice, two clocks.
// RQ4 - 35x18 step one: zero-extended low A times B.
// RQ5 - First partial low 17 bits are result 16:0.
// RQ6 - 35x18 step two: shifted feedback plus upper A.
// RQ7 - Step two low 36 bits are result 52:17.
// RQ8 - 35x35 mode: signed 70-bit product, four clocks.
// RQ9 - 35x35 step one: both low parts, load.
// RQ10 - Products sign extended to 48 bits.
// RQ11 - 35x35 step two: shift, add upper A, low B.
// RQ12 - Step three: accumulate upper B, low A.
// RQ13 - Step four: shift, add both upper parts.
// RQ14 - 70-bit result delivered as 17, 17, 36 bits.
// RQ15 - Optional pipeline registers add latency only.
// RQ16 - Load code routes zero into third input.
// RQ17 - Accumulate code feeds back the result register.
// RQ18 - Driver holds operands, no early restart.
// RQ19 - One-cycle valid with every emitted segment.
`timescale 1ns/10ps

module wm_mult #(
   parameter int USE_MREG = 0
)(
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_reset_n,
   input  wire logic                       i_start,
   input  wire logic                       i_mode,
   input  wire logic [wm_pkg::OP_W-1:0]    i_op_a,
   input  wire logic [wm_pkg::OP_W-1:0]    i_op_b,
   output logic                            o_busy,
   output logic                            o_seg_valid,
   output logic      [1:0]                 o_seg_index,
   output logic                            o_seg_last,
   output logic      [wm_pkg::SEG_W-1:0]   o_seg_data,
   output logic      [wm_pkg::SEL_W-1:0]   o_select_code
);

   // ==========================================================
   // Declarations
   // ==========================================================
   localparam logic [1:0] GAP = 2'(USE_MREG);

   wm_slice_if slice_bus ();

   wm_pkg::wm_state_e                state;
   wm_pkg::wm_state_e                next_state;
   wm_pkg::wm_mode_e                 mode;
   wm_pkg::wm_mode_e                 next_mode;
   logic [wm_pkg::OP_W-1:0]          op_a;
   logic [wm_pkg::OP_W-1:0]          next_op_a;
   logic [wm_pkg::OP_W-1:0]          op_b;
   logic [wm_pkg::OP_W-1:0]          next_op_b;
   logic [1:0]                       step;
   logic [1:0]                       next_step;
   logic [1:0]                       gap;
   logic [1:0]                       next_gap;
   logic [1:0]                       last_step;
   logic signed [wm_pkg::SLICE_W-1:0] drv_a;
   logic signed [wm_pkg::SLICE_W-1:0] next_drv_a;
   logic signed [wm_pkg::SLICE_W-1:0] drv_b;
   logic signed [wm_pkg::SLICE_W-1:0] next_drv_b;
   logic [wm_pkg::SEL_W-1:0]         drv_sel;
   logic [wm_pkg::SEL_W-1:0]         next_drv_sel;
   logic                             drv_en;
   logic                             next_drv_en;
   logic [1:0]                       drv_tag;
   logic [1:0]                       next_drv_tag;
   logic                             busy;
   logic                             next_busy;
   logic                             seg_valid;
   logic                             next_seg_valid;
   logic [1:0]                       seg_index;
   logic [1:0]                       next_seg_index;
   logic                             seg_last;
   logic                             next_seg_last;
   logic [wm_pkg::SEG_W-1:0]         seg_data;
   logic [wm_pkg::SEG_W-1:0]         next_seg_data;
   logic signed [wm_pkg::SLICE_W-1:0] a_low;
   logic signed [wm_pkg::SLICE_W-1:0] a_high;
   logic signed [wm_pkg::SLICE_W-1:0] b_low;
   logic signed [wm_pkg::SLICE_W-1:0] b_high;
   logic signed [wm_pkg::SLICE_W-1:0] b_full;

   // ==========================================================
   // Operand slices
   // ==========================================================
   // The low part carries a forced zero on top so that it
   // multiplies as a positive number; this is why an operand can
   // only hold 35 bits rather than 36.
   assign a_low  = {1'b0, op_a[wm_pkg::LOW_W-1:0]}; // [RQ2]
   assign b_low  = {1'b0, op_b[wm_pkg::LOW_W-1:0]}; // [RQ2]
   assign a_high = op_a[wm_pkg::OP_W-1:wm_pkg::LOW_W];
   assign b_high = op_b[wm_pkg::OP_W-1:wm_pkg::LOW_W];
   assign b_full = op_b[wm_pkg::SLICE_W-1:0]; // [RQ1]

   assign last_step = (mode == wm_pkg::WM_MODE_35X35) ?
                      wm_pkg::STEP_3 : wm_pkg::STEP_1; // [RQ3] [RQ8]

   // ==========================================================
   // Sequencer
   // ==========================================================
   // Operands are captured at the start so the slice always sees
   // one consistent pair, even if the driver lets them move.
   always_comb
   begin
      next_state   = state;
      next_mode    = mode;
      next_op_a    = op_a;
      next_op_b    = op_b;
      next_step    = step;
      next_gap     = gap;
      next_drv_a   = drv_a;
      next_drv_b   = drv_b;
      next_drv_sel = drv_sel;
      next_drv_en  = 1'b0;
      next_drv_tag = drv_tag;
      unique case (state)
         wm_pkg::WM_ST_IDLE :
         begin
            if (i_start)
            begin
               next_mode  = wm_pkg::wm_mode_e'(i_mode);
               next_op_a  = i_op_a; // [RQ18]
               next_op_b  = i_op_b;
               next_step  = wm_pkg::STEP_0;
               next_gap   = 2'h0;
               next_state = wm_pkg::WM_ST_RUN;
            end
         end
         wm_pkg::WM_ST_RUN :
         begin
            if (gap != 2'h0)
            begin
               next_gap = gap - 2'h1; // [RQ15]
            end
            else
            begin
               next_drv_en  = 1'b1;
               next_drv_tag = step;
               next_gap     = GAP;
               if (mode == wm_pkg::WM_MODE_35X18)
               begin
                  next_drv_b = b_full; // [RQ1]
                  if (step == wm_pkg::STEP_0)
                  begin
                     next_drv_a   = a_low; // [RQ4]
                     next_drv_sel = wm_pkg::SEL_LOAD; // [RQ4]
                  end
                  else
                  begin
                     next_drv_a   = a_high; // [RQ6]
                     next_drv_sel = wm_pkg::SEL_SHIFT_ACC; // [RQ6]
                  end
               end
               else
               begin
                  unique case (step)
                     wm_pkg::STEP_0 :
                     begin
                        next_drv_a   = a_low; // [RQ9]
                        next_drv_b   = b_low;
                        next_drv_sel = wm_pkg::SEL_LOAD; // [RQ9]
                     end
                     wm_pkg::STEP_1 :
                     begin
                        next_drv_a   = a_high; // [RQ11]
                        next_drv_b   = b_low;
                        next_drv_sel = wm_pkg::SEL_SHIFT_ACC; // [RQ11]
                     end
                     wm_pkg::STEP_2 :
                     begin
                        next_drv_a   = a_low; // [RQ12]
                        next_drv_b   = b_high;
                        next_drv_sel = wm_pkg::SEL_ACC; // [RQ12]
                     end
                     wm_pkg::STEP_3 :
                     begin
                        next_drv_a   = a_high; // [RQ13]
                        next_drv_b   = b_high;
                        next_drv_sel = wm_pkg::SEL_SHIFT_ACC; // [RQ13]
                     end
                  endcase
               end
               if (step == last_step)
               begin
                  next_state = wm_pkg::WM_ST_DRAIN;
               end
               else
               begin
                  next_step = step + 2'h1;
               end
            end
         end
         wm_pkg::WM_ST_DRAIN :
         begin
            if (slice_bus.p_valid && (slice_bus.p_tag == last_step))
            begin
               next_state = wm_pkg::WM_ST_IDLE;
            end
         end
         default :
         begin
            next_state = wm_pkg::WM_ST_IDLE;
         end
      endcase
      next_busy = (next_state != wm_pkg::WM_ST_IDLE);
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state   <= wm_pkg::WM_ST_IDLE;
         mode    <= wm_pkg::WM_MODE_35X18;
         op_a    <= '0;
         op_b    <= '0;
         step    <= wm_pkg::STEP_0;
         gap     <= 2'h0;
         drv_a   <= '0;
         drv_b   <= '0;
         drv_sel <= wm_pkg::SEL_RESET;
         drv_en  <= 1'b0;
         drv_tag <= 2'h0;
         busy    <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         mode    <= next_mode;
         op_a    <= next_op_a;
         op_b    <= next_op_b;
         step    <= next_step;
         gap     <= next_gap;
         drv_a   <= next_drv_a;
         drv_b   <= next_drv_b;
         drv_sel <= next_drv_sel;
         drv_en  <= next_drv_en;
         drv_tag <= next_drv_tag;
         busy    <= next_busy;
      end
   end

   // ==========================================================
   // Multiply-add slice
   // ==========================================================
   assign slice_bus.a                    = drv_a;
   assign slice_bus.b                    = drv_b;
   assign slice_bus.datapath_select_code = drv_sel;
   assign slice_bus.en                   = drv_en;
   assign slice_bus.tag                  = drv_tag;

   wm_slice #(
      .USE_MREG (USE_MREG)
   ) u_slice (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .bus       (slice_bus)
   );

   // ==========================================================
   // Result segments
   // ==========================================================
   // Segments are taken from the result register the cycle after
   // it is written, so a step's result is never read half-formed.
   always_comb
   begin
      next_seg_valid = 1'b0;
      next_seg_index = seg_index;
      next_seg_last  = 1'b0;
      next_seg_data  = seg_data;
      if (slice_bus.p_valid)
      begin
         if (slice_bus.p_tag == last_step)
         begin
            next_seg_valid = 1'b1; // [RQ19]
            next_seg_last  = 1'b1;
            next_seg_data  = slice_bus.p[wm_pkg::SEG_W-1:0]; // [RQ7]
            next_seg_index = (mode == wm_pkg::WM_MODE_35X35) ?
                             wm_pkg::SEG_2 : wm_pkg::SEG_1; // [RQ14]
         end
         else if (slice_bus.p_tag == wm_pkg::STEP_0)
         begin
            next_seg_valid = 1'b1; // [RQ19]
            next_seg_index = wm_pkg::SEG_0;
            next_seg_data  = {{(wm_pkg::SEG_W-wm_pkg::LOW_W){1'b0}},
                              slice_bus.p[wm_pkg::LOW_W-1:0]}; // [RQ5]
         end
         else if (slice_bus.p_tag == wm_pkg::STEP_2)
         begin
            next_seg_valid = 1'b1; // [RQ19]
            next_seg_index = wm_pkg::SEG_1; // [RQ14]
            next_seg_data  = {{(wm_pkg::SEG_W-wm_pkg::LOW_W){1'b0}},
                              slice_bus.p[wm_pkg::LOW_W-1:0]}; // [RQ12]
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         seg_valid <= 1'b0;
         seg_index <= wm_pkg::SEG_0;
         seg_last  <= 1'b0;
         seg_data  <= '0;
      end
      else
      begin
         seg_valid <= next_seg_valid;
         seg_index <= next_seg_index;
         seg_last  <= next_seg_last;
         seg_data  <= next_seg_data;
      end
   end

   assign o_busy        = busy;
   assign o_seg_valid   = seg_valid;
   assign o_seg_index   = seg_index;
   assign o_seg_last    = seg_last;
   assign o_seg_data    = seg_data;
   assign o_select_code = drv_sel;

endmodule

// [verification/wm_fabric_model.sv]
`timescale 1ns/10ps

module wm_fabric_model (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_busy,
   output logic                       o_start,
   output logic                       o_mode,
   output logic [wm_pkg::OP_W-1:0]    o_op_a,
   output logic [wm_pkg::OP_W-1:0]    o_op_b
);
   // ==========================================================
   // Request driver
   // ==========================================================
   initial
   begin
      o_start = 1'b0;
      o_mode  = 1'b0;
      o_op_a  = 35'h000000000;
      o_op_b  = 35'h000000000;
   end

   // Call at a falling edge; returns at the falling edge where busy is
   // low again, so a following call starts back to back.
   task automatic go(input logic m, input logic [34:0] a,
                     input logic [34:0] b, input logic hold);
      o_start = 1'b1;
      o_mode  = m;
      o_op_a  = a;
      o_op_b  = b;
      @(negedge i_clk_sys);
      while (i_busy === 1'b1)
      begin
         // The hold variant leaves the request standing while busy,
         // which the block must ignore; operands never move early.
         if (!hold)
         begin
            o_start = 1'b0;
         end
         @(negedge i_clk_sys);
      end
   endtask

   task automatic idle();
      o_start = 1'b0;
      o_op_a  = ~o_op_a;
      o_op_b  = ~o_op_b;
   endtask
endmodule

// [verification/wm_mult_monitor.sv]
`timescale 1ns/10ps

module wm_mult_monitor #(
   parameter int USE_MREG = 0
)(
   input wire logic                      i_clk_sys,
   input wire logic                      i_reset_n,
   input wire logic                      i_start,
   input wire logic                      i_mode,
   input wire logic [wm_pkg::OP_W-1:0]   i_op_a,
   input wire logic [wm_pkg::OP_W-1:0]   i_op_b,
   input wire logic                      o_busy,
   input wire logic                      o_seg_valid,
   input wire logic [1:0]                o_seg_index,
   input wire logic                      o_seg_last,
   input wire logic [wm_pkg::SEG_W-1:0]  o_seg_data,
   input wire logic [wm_pkg::SEL_W-1:0]  o_select_code
);
   // ==========================================================
   // Timing checks, valid for the build without product register
   // ==========================================================
   logic take;
   assign take = i_start && !o_busy && (USE_MREG == 0);

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   load_code_a: assert property (take |-> ##2 o_select_code == 7'h05)
      else $error("load code missing");
   shift_code_a: assert property (take |-> ##3 o_select_code == 7'h65)
      else $error("shift code missing");
   acc_code_a: assert property (take && i_mode |-> ##4
      o_select_code == 7'h25 ##1 o_select_code == 7'h65)
      else $error("accumulate codes missing");
   short_run_a: assert property (take && !i_mode |-> ##4
      o_seg_valid && o_seg_index == 2'h0 && !o_seg_last ##1
      o_seg_valid && o_seg_index == 2'h1 && o_seg_last)
      else $error("short segments mistimed");
   long_run_a: assert property (take && i_mode |-> ##4
      o_seg_valid && o_seg_index == 2'h0 ##1 !o_seg_valid ##1
      o_seg_valid && o_seg_index == 2'h1 ##1
      o_seg_valid && o_seg_index == 2'h2 && o_seg_last)
      else $error("long segments mistimed");
   short_busy_a: assert property (take && !i_mode |=> o_busy [*4] ##1 !o_busy)
      else $error("short busy span wrong");
   long_busy_a: assert property (take && i_mode |=> o_busy [*6] ##1 !o_busy)
      else $error("long busy span wrong");
   last_pulse_a: assert property (o_seg_last |=> !o_seg_last)
      else $error("last flag too long");
   last_valid_a: assert property (o_seg_last |-> o_seg_valid && !o_busy)
      else $error("last flag without valid");
   narrow_seg_a: assert property (o_seg_valid && !o_seg_last |->
      o_seg_data[35:17] == 19'h00000)
      else $error("narrow segment not zero extended");

   cover property (take && !i_mode);
   cover property (take && i_mode);
   cover property (o_seg_last && i_start);
endmodule

bind wm_mult wm_mult_monitor #(.USE_MREG(USE_MREG)) mon_u (
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_start(i_start),
   .i_mode(i_mode), .i_op_a(i_op_a), .i_op_b(i_op_b), .o_busy(o_busy),
   .o_seg_valid(o_seg_valid), .o_seg_index(o_seg_index),
   .o_seg_last(o_seg_last), .o_seg_data(o_seg_data),
   .o_select_code(o_select_code));

// [verification/test_wm_mult.sv]
`timescale 1ns/10ps

module test_wm_mult;
   logic                      clk;
   logic                      reset_n;
   logic                      start;
   logic                      mode;
   logic [wm_pkg::OP_W-1:0]   op_a;
   logic [wm_pkg::OP_W-1:0]   op_b;
   logic                      busy;
   logic                      seg_valid;
   logic [1:0]                seg_index;
   logic                      seg_last;
   logic [wm_pkg::SEG_W-1:0]  seg_data;
   logic [wm_pkg::SEL_W-1:0]  sel_code;
   logic                      start_0;
   logic                      start_1;
   logic                      busy_any;
   logic                      busy_m;
   logic                      seg_valid_m;
   logic [1:0]                seg_index_m;
   logic                      seg_last_m;
   logic [wm_pkg::SEG_W-1:0]  seg_data_m;
   logic [38:0]               expq[$];
   logic [38:0]               expq_m[$];
   logic [38:0]               got;
   logic [38:0]               want;
   int                        n_fail;
   int                        num_checks;

   // Operand table: extremes, a low part with bit 16 set, garbage in the
   // unused upper bits of the narrow operand.
   localparam logic M_T [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   localparam logic H_T [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   localparam logic [34:0] A_T [6] = '{35'h400000000, 35'h00001FFFF,
      35'h400000000, 35'h7FFFFFFFF, 35'h123456789, 35'h2AAAAAAAA};
   localparam logic [34:0] B_T [6] = '{35'h7FFE20000, 35'h00003FFFF,
      35'h400000000, 35'h3FFFFFFFF, 35'h6DCBA9876, 35'h000015555};

   // ==========================================================
   // Clock, design and partner
   // ==========================================================
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Each copy takes a start only while both are idle, so the plain
   // and the piped build always work on the same operand pair.
   assign start_0  = start && !busy_m;
   assign start_1  = start && !busy;
   assign busy_any = busy || busy_m;

   wm_mult #(.USE_MREG(0)) dut_u (
      .i_clk_sys(clk), .i_reset_n(reset_n), .i_start(start_0),
      .i_mode(mode), .i_op_a(op_a), .i_op_b(op_b), .o_busy(busy),
      .o_seg_valid(seg_valid), .o_seg_index(seg_index),
      .o_seg_last(seg_last), .o_seg_data(seg_data),
      .o_select_code(sel_code));

   wm_mult #(.USE_MREG(1)) dut_pipe_u (
      .i_clk_sys(clk), .i_reset_n(reset_n), .i_start(start_1),
      .i_mode(mode), .i_op_a(op_a), .i_op_b(op_b), .o_busy(busy_m),
      .o_seg_valid(seg_valid_m), .o_seg_index(seg_index_m),
      .o_seg_last(seg_last_m), .o_seg_data(seg_data_m),
      .o_select_code());

   wm_fabric_model fab_u (
      .i_clk_sys(clk), .i_busy(busy_any), .o_start(start), .o_mode(mode),
      .o_op_a(op_a), .o_op_b(op_b));

   // ==========================================================
   // Checking
   // ==========================================================
   task automatic chk(input string name, input logic [38:0] exp,
                      input logic [38:0] seen);
      num_checks++;
      if (exp !== seen)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Full-width signed product; the segments are slices of it.
   task automatic expect_op(input logic m, input logic [34:0] a,
                            input logic [34:0] b);
      logic [69:0] xa;
      logic [69:0] xb;
      logic [69:0] p;
      logic [38:0] s[$];
      xa = {{35{a[34]}}, a};
      xb = m ? {{35{b[34]}}, b} : {{52{b[17]}}, b[17:0]};
      p  = xa * xb;
      s.push_back({2'h0, 1'b0, 19'h00000, p[16:0]});
      if (m)
      begin
         s.push_back({2'h1, 1'b0, 19'h00000, p[33:17]});
         s.push_back({2'h2, 1'b1, p[69:34]});
      end
      else
         s.push_back({2'h1, 1'b1, p[52:17]});
      foreach (s[k])
      begin
         expq.push_back(s[k]);
         expq_m.push_back(s[k]);
      end
   endtask

   // Segments stand for one cycle; sample them mid-cycle.
   always @(negedge clk)
   begin
      if (seg_valid === 1'b1)
      begin
         got  = {seg_index, seg_last, seg_data};
         want = (expq.size() > 0) ? expq.pop_front() : {39{1'bx}};
         chk("segment", want, got);
      end
      if (seg_valid_m === 1'b1)
      begin
         got  = {seg_index_m, seg_last_m, seg_data_m};
         want = (expq_m.size() > 0) ? expq_m.pop_front() : {39{1'bx}};
         chk("piped segment", want, got);
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Sequence
   // ==========================================================
   initial
   begin
      n_fail     = 0;
      num_checks = 0;
      reset_n    = 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      chk("idle busy", 39'h0, {38'h0, busy});
      chk("piped idle busy", 39'h0, {38'h0, busy_m});
      chk("reset code", 39'h0, {32'h0, sel_code});
      for (int i = 0; i < 6; i++)
      begin
         expect_op(M_T[i], A_T[i], B_T[i]);
         fab_u.go(M_T[i], A_T[i], B_T[i], H_T[i]);
      end
      fab_u.idle();
      repeat (16) @(negedge clk);
      chk("pending", 39'h0, 39'(expq.size()));
      chk("piped pending", 39'h0, 39'(expq_m.size()));
      tally_and_finish();
   end

   initial
   begin
      repeat (600) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule
